// ==== design/dfsps_pkg.sv ====
package dfsps_pkg;

  // Instruction register width and command codes for the scan controller.
  localparam int unsigned IR_WIDTH = 4;
  localparam logic [3:0] IR_RESET_VAL = 4'h1;
  localparam logic [3:0] CMD_BYPASS = 4'hF;
  localparam logic [3:0] CMD_IDCODE = 4'h1;
  localparam logic [3:0] CMD_PROGRAM = 4'h2;

  // Programming shift register width and reset value.
  localparam int unsigned PROG_WIDTH = 16;
  localparam logic [15:0] PROG_RESET_VAL = 16'h0000;

  // Identification word; the value is arbitrary.
  localparam logic [31:0] ID_CODE_VAL = 32'h0000_1001;

  // Capture pattern loaded into the instruction register.
  localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;

  // Link clock period as printed for the bench, in ns, and system period.
  localparam int unsigned LINK_PERIOD_NS = 125;
  localparam int unsigned SYS_PERIOD_NS = 10;

  // Scan controller states, one-hot.
  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAP_DR     = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPD_DR     = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAP_IR     = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPD_IR     = 16'h8000
  } dfsps_state_e;

endpackage

// ==== design/dfsps_scan_port.sv ====
// Function
// - Sample serial input and mode control on each rising test clock edge.
// - Change serial output only after a falling test clock edge.
// - Mode control steers the scan controller state machine.
// - Programming data enters bit by bit on the serial input.
// - Programming data leaves bit by bit on the serial output.
// - Port select high gives shared pins their programming function.
// - Port select low makes shared pins ordinary user I/O.
// - High-voltage select enables programming only at supervoltage; low is I/O.
// - Without a select pin, the four pins stay dedicated to programming.
// - Any number of devices may be cascaded in one chain.
// - Each serial output feeds the next device's serial input.
`timescale 1ns/10ps
`default_nettype none

module dfsps_scan_port #(
  parameter bit HAS_SELECT   = 1'b1,
  parameter bit HIGH_VOLTAGE = 1'b0,
  parameter int unsigned PROG_W = dfsps_pkg::PROG_WIDTH
) (
  // System clock and reset.
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Scan pins as seen through the shared pads.
  input  wire logic              tck_pin,
  input  wire logic              alt_serial_in,
  input  wire logic              alt_mode_control,
  output var  logic              alt_serial_out,
  output var  logic              alt_serial_out_oe,
  // Port select straps; the high-voltage input is the supervoltage detector.
  input  wire logic              scan_port_select,
  input  wire logic              high_voltage_port_select,
  // User I/O path of the four shared pads.
  input  wire logic [3:0]        user_out,
  input  wire logic [3:0]        user_oe,
  output var  logic [3:0]        user_in,
  output var  logic [3:0]        pad_out,
  output var  logic [3:0]        pad_oe,
  input  wire logic [3:0]        pad_in,
  // Programming results.
  output var  logic [PROG_W-1:0] prog_word,
  output var  logic              prog_strobe,
  output var  logic              scan_mode
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic [1:0] tck_sync_reg;
  logic [1:0] tdi_sync_reg;
  logic [1:0] tms_sync_reg;
  logic [1:0] sel_sync_reg;
  logic [1:0] hv_sync_reg;
  logic [3:0] pad_s1_reg;
  logic [3:0] pad_s2_reg;
  logic       tck_prev_reg;

  // Every off-domain input passes two flops before anything reads it.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tck_sync_reg <= 2'h0;
      tdi_sync_reg <= 2'h0;
      tms_sync_reg <= 2'h3;
      sel_sync_reg <= 2'h0;
      hv_sync_reg  <= 2'h0;
      pad_s1_reg   <= 4'h0;
      pad_s2_reg   <= 4'h0;
      tck_prev_reg <= 1'b0;
    end
    else
    begin
      tck_sync_reg <= {tck_sync_reg[0], tck_pin};
      tdi_sync_reg <= {tdi_sync_reg[0], alt_serial_in};
      tms_sync_reg <= {tms_sync_reg[0], alt_mode_control};
      sel_sync_reg <= {sel_sync_reg[0], scan_port_select};
      hv_sync_reg  <= {hv_sync_reg[0], high_voltage_port_select};
      pad_s1_reg   <= pad_in;
      pad_s2_reg   <= pad_s1_reg;
      tck_prev_reg <= tck_sync_reg[1];
    end
  end

  logic tck_rise;
  logic tck_fall;
  logic tdi_s;
  logic tms_s;
  logic mode_sel;

  assign tck_rise = tck_sync_reg[1] & ~tck_prev_reg;
  assign tck_fall = ~tck_sync_reg[1] & tck_prev_reg;
  assign tdi_s    = tdi_sync_reg[1];
  assign tms_s    = tms_sync_reg[1];

  // Function select.
  // The high-voltage detector output is high only at supervoltage.
  assign mode_sel = !HAS_SELECT ? 1'b1 :
                    (HIGH_VOLTAGE ? hv_sync_reg[1] : sel_sync_reg[1]);

  // Controller only advances while the programming function is selected.
  logic adv_rise;
  logic adv_fall;
  assign adv_rise = tck_rise & mode_sel;
  assign adv_fall = tck_fall & mode_sel;

  ////////////////////////////////////////////////////////////////////////
  // Scan controller.

  dfsps_pkg::dfsps_state_e state_reg;
  dfsps_pkg::dfsps_state_e state_next;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      dfsps_pkg::ST_RESET:
        state_next = tms_s ? dfsps_pkg::ST_RESET : dfsps_pkg::ST_IDLE;
      dfsps_pkg::ST_IDLE:
        state_next = tms_s ? dfsps_pkg::ST_SEL_DR : dfsps_pkg::ST_IDLE;
      dfsps_pkg::ST_SEL_DR:
        state_next = tms_s ? dfsps_pkg::ST_SEL_IR : dfsps_pkg::ST_CAP_DR;
      dfsps_pkg::ST_CAP_DR,
      dfsps_pkg::ST_SHIFT_DR:
        state_next = tms_s ? dfsps_pkg::ST_EXIT1_DR : dfsps_pkg::ST_SHIFT_DR;
      dfsps_pkg::ST_EXIT1_DR:
        state_next = tms_s ? dfsps_pkg::ST_UPD_DR : dfsps_pkg::ST_PAUSE_DR;
      dfsps_pkg::ST_PAUSE_DR:
        state_next = tms_s ? dfsps_pkg::ST_EXIT2_DR : dfsps_pkg::ST_PAUSE_DR;
      dfsps_pkg::ST_EXIT2_DR:
        state_next = tms_s ? dfsps_pkg::ST_UPD_DR : dfsps_pkg::ST_SHIFT_DR;
      dfsps_pkg::ST_UPD_DR,
      dfsps_pkg::ST_UPD_IR:
        state_next = tms_s ? dfsps_pkg::ST_SEL_DR : dfsps_pkg::ST_IDLE;
      dfsps_pkg::ST_SEL_IR:
        state_next = tms_s ? dfsps_pkg::ST_RESET : dfsps_pkg::ST_CAP_IR;
      dfsps_pkg::ST_CAP_IR,
      dfsps_pkg::ST_SHIFT_IR:
        state_next = tms_s ? dfsps_pkg::ST_EXIT1_IR : dfsps_pkg::ST_SHIFT_IR;
      dfsps_pkg::ST_EXIT1_IR:
        state_next = tms_s ? dfsps_pkg::ST_UPD_IR : dfsps_pkg::ST_PAUSE_IR;
      dfsps_pkg::ST_PAUSE_IR:
        state_next = tms_s ? dfsps_pkg::ST_EXIT2_IR : dfsps_pkg::ST_PAUSE_IR;
      dfsps_pkg::ST_EXIT2_IR:
        state_next = tms_s ? dfsps_pkg::ST_UPD_IR : dfsps_pkg::ST_SHIFT_IR;
      default:
        state_next = dfsps_pkg::ST_RESET;
    endcase
  end

  // Controller holds state while pins serve as user I/O.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_reg <= dfsps_pkg::ST_RESET;
    else if (adv_rise)
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Instruction and data registers.

  logic [3:0]        ir_shift_reg;
  logic [3:0]        ir_reg;
  logic [31:0]       id_shift_reg;
  logic              bypass_reg;
  logic [PROG_W-1:0] prog_shift_reg;

  // Instruction path; test-logic-reset reloads the default instruction.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ir_shift_reg <= dfsps_pkg::IR_RESET_VAL;
      ir_reg       <= dfsps_pkg::IR_RESET_VAL;
    end
    else if (adv_rise)
    begin
      unique case (state_reg)
        dfsps_pkg::ST_RESET:
          ir_reg <= dfsps_pkg::IR_RESET_VAL;
        dfsps_pkg::ST_CAP_IR:
          ir_shift_reg <= dfsps_pkg::IR_CAPTURE_VAL;
        dfsps_pkg::ST_SHIFT_IR:
          ir_shift_reg <= {tdi_s, ir_shift_reg[3:1]};
        dfsps_pkg::ST_UPD_IR:
          ir_reg <= ir_shift_reg;
        default:
          ir_reg <= ir_reg;
      endcase
    end
  end

  // Serial data in.
  // Data registers capture and shift on the rising edge only.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      id_shift_reg   <= dfsps_pkg::ID_CODE_VAL;
      bypass_reg     <= 1'b0;
      prog_shift_reg <= PROG_W'(dfsps_pkg::PROG_RESET_VAL);
    end
    else if (adv_rise)
    begin
      if (state_reg == dfsps_pkg::ST_CAP_DR)
      begin
        id_shift_reg <= dfsps_pkg::ID_CODE_VAL;
        bypass_reg   <= 1'b0;
      end
      else if (state_reg == dfsps_pkg::ST_SHIFT_DR)
      begin
        id_shift_reg <= {tdi_s, id_shift_reg[31:1]};
        bypass_reg   <= tdi_s;
        if (ir_reg == dfsps_pkg::CMD_PROGRAM)
          prog_shift_reg <= {tdi_s, prog_shift_reg[PROG_W-1:1]};
      end
    end
  end

  // Completed programming words are presented on update.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prog_word   <= PROG_W'(dfsps_pkg::PROG_RESET_VAL);
      prog_strobe <= 1'b0;
    end
    else
    begin
      prog_strobe <= 1'b0;
      if (adv_rise && state_reg == dfsps_pkg::ST_UPD_DR &&
          ir_reg == dfsps_pkg::CMD_PROGRAM)
      begin
        prog_word   <= prog_shift_reg;
        prog_strobe <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial output, launched on the falling edge.

  // Bypass bit keeps chains short.
  // Any instruction other than identify or program selects the bypass bit.
  logic tdo_bit;
  always_comb
  begin
    tdo_bit = bypass_reg;
    if (state_reg == dfsps_pkg::ST_SHIFT_IR)
      tdo_bit = ir_shift_reg[0];
    else if (ir_reg == dfsps_pkg::CMD_IDCODE)
      tdo_bit = id_shift_reg[0];
    else if (ir_reg == dfsps_pkg::CMD_PROGRAM)
      tdo_bit = prog_shift_reg[0];
  end

  // Output drives only while shifting so chains share the return.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      alt_serial_out    <= 1'b0;
      alt_serial_out_oe <= 1'b0;
    end
    else if (!mode_sel)
      alt_serial_out_oe <= 1'b0;
    else if (adv_fall)
    begin
      alt_serial_out    <= tdo_bit;
      alt_serial_out_oe <= (state_reg == dfsps_pkg::ST_SHIFT_DR) ||
                           (state_reg == dfsps_pkg::ST_SHIFT_IR);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared pad multiplexing.

  // User I/O path.
  // User drivers are released while programming so the pads see no fight.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pad_out   <= 4'h0;
      pad_oe    <= 4'h0;
      user_in   <= 4'h0;
      scan_mode <= 1'b0;
    end
    else
    begin
      scan_mode <= mode_sel;
      pad_out   <= user_out;
      pad_oe    <= mode_sel ? 4'h0 : user_oe;
      user_in   <= mode_sel ? 4'h0 : pad_s2_reg;
    end
  end

endmodule

`default_nettype wire

// ==== sim/dfsps_prog_source.sv ====
`timescale 1ns/10ps
`default_nettype none
// Programming source; its clock stands low between frames.
module dfsps_prog_source (
  // Scan pins to the device.
  output var logic tck,
  output var logic tdi,
  output var logic tms,
  output var logic sel,
  // Board indicator.
  output var logic active_n,
  // Returned serial data.
  input  wire logic tdo
);
  initial
  begin
    {tck, tdi, tms, sel} = 4'h0;
  end
  always_comb active_n = ~sel;
  ////////////////////////////////
  // Select moves half way between system clock edges to avoid races.
  task automatic set_sel(input logic s);
    #2.5;
    sel = s;
    #2.5;
  endtask
  // Setup while low.
  // Data is inverted after the edge so a late sample shows.
  // Every pin change sits half way between system clock edges.
  task automatic bit_io(input logic m, input logic d, output logic b);
    #2.5;
    tdi = d;
    tms = m;
    #60;
    b = tdo;
    tck = 1'b1;
    #60;
    tck = 1'b0;
    tdi = ~d;
    #2.5;
  endtask
  task automatic moves(input logic [7:0] m, input int n);
    logic b;
    for (int i = 0; i < n; i++)
      bit_io(m[i], 1'b0, b);
  endtask
  // LSB first, mode high on last bit.
  task automatic scan(input logic [31:0] v, input int n,
                      output logic [31:0] q);
    logic b;
    q = 32'h0000_0000;
    for (int i = 0; i < n; i++)
    begin
      bit_io(i == n - 1, v[i], b);
      q[i] = b;
    end
  endtask
endmodule
`default_nettype wire

// ==== sim/dfsps_scan_port_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
// Ties the pad and scan outputs to select and test clock.
module dfsps_scan_port_sva #(
  parameter int unsigned PROG_W = dfsps_pkg::PROG_WIDTH
) (
  // Clock and reset.
  input wire logic              clk,
  input wire logic              rst_n,
  // Pins and results.
  input wire logic              tck_pin,
  input wire logic              scan_port_select,
  input wire logic [3:0]        user_oe,
  input wire logic [3:0]        user_in,
  input wire logic [3:0]        pad_oe,
  input wire logic              alt_serial_out,
  input wire logic              alt_serial_out_oe,
  input wire logic [PROG_W-1:0] prog_word,
  input wire logic              prog_strobe,
  input wire logic              scan_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////
  pad_free_a: assert property (
    scan_mode |-> pad_oe == 4'h0 && user_in == 4'h0) else $error("pad on");
  io_quiet_a: assert property (
    !scan_mode |-> !alt_serial_out_oe) else $error("scan out on");
  sel_on_a: assert property (
    $rose(scan_port_select) |-> ##[1:6] scan_mode) else $error("no mode");
  sel_off_a: assert property (
    $fell(scan_port_select) |-> ##[1:6] !scan_mode) else $error("mode");
  out_fall_a: assert property (
    $changed(alt_serial_out) |-> !tck_pin) else $error("early out");
  word_strobe_a: assert property (
    $changed(prog_word) |-> prog_strobe) else $error("silent word");
  strobe_one_a: assert property (
    prog_strobe |-> scan_mode ##1 !prog_strobe) else $error("strobe");
  io_drive_a: assert property (
    !scan_mode && $past(scan_mode) == 1'b0 |-> pad_oe == $past(user_oe))
    else $error("pad oe");
endmodule
bind dfsps_scan_port dfsps_scan_port_sva #(.PROG_W(PROG_W)) u_sva (
  .clk(clk), .rst_n(rst_n), .tck_pin(tck_pin),
  .scan_port_select(scan_port_select), .user_oe(user_oe),
  .user_in(user_in), .pad_oe(pad_oe), .alt_serial_out(alt_serial_out),
  .alt_serial_out_oe(alt_serial_out_oe), .prog_word(prog_word),
  .prog_strobe(prog_strobe), .scan_mode(scan_mode));
`default_nettype wire

// ==== sim/dfsps_scan_port_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// Pad traffic and scan frames across select changes.
module dfsps_scan_port_tb;
  logic        clk, rst_n, tck, tdi, tms, sel, act_n, tdo, oe, stb, mode;
  logic        mode_hv, mode_fx;
  logic [3:0]  uo, ue, ui, po, pe, pi;
  logic [15:0] word, got, w, word_hv;
  logic [31:0] q, r;
  int          mismatches, comparisons, cycles, n_stb;
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  dfsps_scan_port u_dfsps_scan_port (
    .clk(clk), .rst_n(rst_n), .tck_pin(tck), .alt_serial_in(tdi),
    .alt_mode_control(tms), .alt_serial_out(tdo), .alt_serial_out_oe(oe),
    .scan_port_select(sel), .high_voltage_port_select(1'b0),
    .user_out(uo), .user_oe(ue), .user_in(ui), .pad_out(po), .pad_oe(pe),
    .pad_in(pi), .prog_word(word), .prog_strobe(stb), .scan_mode(mode));
  // Supervoltage-select and fixed-function variants watch the same pins.
  dfsps_scan_port #(.HIGH_VOLTAGE(1'b1)) u_dfsps_scan_port_hv (
    .clk(clk), .rst_n(rst_n), .tck_pin(tck), .alt_serial_in(tdi),
    .alt_mode_control(tms), .alt_serial_out(), .alt_serial_out_oe(),
    .scan_port_select(1'b0), .high_voltage_port_select(sel),
    .user_out(uo), .user_oe(ue), .user_in(), .pad_out(), .pad_oe(),
    .pad_in(pi), .prog_word(word_hv), .prog_strobe(), .scan_mode(mode_hv));
  dfsps_scan_port #(.HAS_SELECT(1'b0)) u_dfsps_scan_port_fx (
    .clk(clk), .rst_n(rst_n), .tck_pin(tck), .alt_serial_in(tdi),
    .alt_mode_control(tms), .alt_serial_out(), .alt_serial_out_oe(),
    .scan_port_select(1'b0), .high_voltage_port_select(1'b0),
    .user_out(uo), .user_oe(ue), .user_in(), .pad_out(), .pad_oe(),
    .pad_in(pi), .prog_word(), .prog_strobe(), .scan_mode(mode_fx));
  // A released serial line reads as the inverse, so a late enable shows.
  dfsps_prog_source u_src (
    .tck(tck), .tdi(tdi), .tms(tms), .sel(sel), .active_n(act_n),
    .tdo(oe ? tdo : ~tdo));
  ////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Pads show user values only outside programming.
  function automatic logic [3:0] pexp(input logic p, input logic [3:0] v);
    return p ? 4'h0 : v;
  endfunction
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected word at %0t: %h %h", $time, g, e);
    end
  endtask
  task automatic cmp_pad(input logic [3:0] g, input logic [3:0] e);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected pad at %0t: %h %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic pads(input logic p);
    repeat (4)
    begin
      @(negedge clk);
      r = nxt(r);
      {uo, ue} = r[11:4];
      // Board drivers let go of the pads while the indicator is low.
      pi = act_n ? r[3:0] : 4'h0;
      repeat (5) @(negedge clk);
      cmp_pad(pe, pexp(p, ue));
      cmp_pad(ui, pexp(p, pi));
      cmp_pad({3'h0, mode}, {3'h0, p});
      cmp_pad({3'h0, mode_hv}, {3'h0, p});
      cmp_pad({3'h0, mode_fx}, 4'h1);
      if (!p) cmp_pad(po, uo);
    end
  endtask
  // Strobes are caught as they pass; the hang limit ends the run.
  always @(posedge clk)
  begin
    cycles++;
    if (stb === 1'b1)
    begin
      got = word;
      n_stb++;
    end
    if (cycles == 20000)
    begin
      mismatches++;
      test_done;
    end
  end
  initial
  begin
    rst_n = 1'b0;
    {uo, ue, pi} = 12'h000;
    r = 32'h0000_13a6;
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp_word(32'({mode, oe, stb, tdo, word}), 32'h0000_0000);
    cmp_pad(pe | ui | po, 4'h0);
    rst_n = 1'b1;
    pads(1'b0);
    u_src.moves(8'hFF, 5);
    u_src.set_sel(1'b1);
    pads(1'b1);
    u_src.moves(8'h02, 4);
    u_src.scan(32'h0000_0000, 32, q);
    cmp_word(q, dfsps_pkg::ID_CODE_VAL);
    u_src.moves(8'h01, 2);
    for (int k = 0; k < 2; k++)
    begin
      r = nxt(r);
      w = k ? r[15:0] : 16'h8001;
      u_src.moves(8'h03, 4);
      u_src.scan({28'h0, dfsps_pkg::CMD_PROGRAM}, 4, q);
      cmp_pad(q[3:0], dfsps_pkg::IR_CAPTURE_VAL);
      u_src.moves(8'h03, 4);
      if (k == 0)
      begin
        u_src.set_sel(1'b0);
        repeat (10) @(negedge clk);
        u_src.moves(8'hFF, 3);
        u_src.set_sel(1'b1);
        repeat (10) @(negedge clk);
      end
      u_src.scan({16'h0, w}, 16, q);
      u_src.moves(8'h01, 2);
      repeat (10) @(negedge clk);
      cmp_word(32'(n_stb), 32'(k + 1));
      cmp_word({16'h0, got}, {16'h0, w});
    end
    // Bypass delays the chain by one bit and never strobes a word.
    r = nxt(r);
    u_src.moves(8'h03, 4);
    u_src.scan({28'h0, dfsps_pkg::CMD_BYPASS}, 4, q);
    cmp_pad(q[3:0], dfsps_pkg::IR_CAPTURE_VAL);
    u_src.moves(8'h03, 4);
    u_src.scan({24'h0, r[7:0]}, 8, q);
    cmp_word(q, {24'h0, r[6:0], 1'b0});
    u_src.moves(8'h01, 2);
    repeat (10) @(negedge clk);
    cmp_word(32'(n_stb), 32'h0000_0002);
    cmp_word({16'h0, word_hv}, {16'h0, w});
    test_done;
  end
endmodule
`default_nettype wire
